// ===== core/wrs_top.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// wake reason status block with AHB-Lite register slave
module wrs_top #(
    parameter int DEBOUNCE_CYCLES = wrs_pkg::DEBOUNCE_CYCLES
) (
    input wire logic clk,
    input wire logic reset,
    // ahb-lite slave
    input wire logic hsel,
    input wire logic [31:0] haddr,
    input wire logic [1:0] htrans,
    input wire logic hwrite,
    input wire logic [2:0] hsize,
    input wire logic [31:0] hwdata,
    input wire logic hready,
    output logic hreadyout,
    output logic [31:0] hrdata,
    output logic hresp,
    // monitored pins, synchronous to clk
    input wire logic cardDetectAPin,
    input wire logic cardDetectBPin,
    input wire logic portPinA,
    input wire logic portPinB,
    input wire logic busPowerPin,
    // level interrupt
    output logic irq
);
    // ======================================================
    // pin debouncing
    logic [wrs_pkg::NUM_PINS-1:0] pinRaw;    // pins in channel order
    logic [wrs_pkg::NUM_PINS-1:0] pinLevel;  // accepted levels
    logic [wrs_pkg::NUM_PINS-1:0] pinChange; // one-cycle change pulses

    assign pinRaw[wrs_pkg::PIN_CARD_A] = cardDetectAPin;
    assign pinRaw[wrs_pkg::PIN_CARD_B] = cardDetectBPin;
    assign pinRaw[wrs_pkg::PIN_PORT_A] = portPinA;
    assign pinRaw[wrs_pkg::PIN_PORT_B] = portPinB;
    assign pinRaw[wrs_pkg::PIN_BUS] = busPowerPin;

    // one debouncer per pin; card pins reset high (absent)
    genvar gi;
    generate
        for (gi = 0; gi < wrs_pkg::NUM_PINS; gi++) begin : g_pin
            wrs_debounce #(
                .CYCLES(DEBOUNCE_CYCLES),
                .RESET_LEVEL(wrs_pkg::LEVEL_RESET[gi])
            ) u_deb (
                .clk(clk),
                .reset(reset),
                .pinIn(pinRaw[gi]),
                .level(pinLevel[gi]),
                .changePulse(pinChange[gi])
            );
        end
    endgenerate

    // ======================================================
    // bus decode
    logic addrPhase;  // transfer accepted this cycle
    logic readAccess; // accepted read
    logic [7:0] offs; // byte offset within the block

    // only the low address byte decodes, so the map aliases above it
    assign addrPhase = hsel && htrans[1] && hready;
    assign readAccess = addrPhase && !hwrite;
    assign offs = haddr[7:0];

    // ======================================================
    // software registers and data-phase state
    logic [3:0] cfg_reg, cfg_next;           // detection enables
    logic usbMask_reg, usbMask_next;         // wake interrupt enable
    logic [3:0] irqMask_reg, irqMask_next;   // irq status mask
    logic dphWrite_reg, dphWrite_next;       // write data phase pending
    logic [7:0] dphAddr_reg, dphAddr_next;   // its offset
    logic [31:0] hrdata_reg, hrdata_next;    // read data
    logic hreadyout_reg;                     // zero wait state slave
    logic hresp_reg;                         // always OKAY
    logic irq_reg, irq_next;                 // interrupt output

    // ======================================================
    // change flags and interrupt status
    logic [wrs_pkg::NUM_FLAGS-1:0] flagSet;   // enabled change events
    logic [wrs_pkg::NUM_FLAGS-1:0] flagClear; // write-one clears
    logic [wrs_pkg::NUM_FLAGS-1:0] flags;     // sticky change flags
    logic [wrs_pkg::NUM_FLAGS-1:0] irqClear;  // read clears
    logic [wrs_pkg::NUM_FLAGS-1:0] irqStat;   // sticky irq status
    logic [7:0] wakeStatus;                   // wake status byte
    logic wrWake;                             // write to wake status

    // enables gate each source; bus power has no enable. Both card
    // pins share one flag, so clearing it clears both sources.
    always_comb begin
        flagSet[wrs_pkg::FLG_CARD] =
            (pinChange[wrs_pkg::PIN_CARD_A] && cfg_reg[wrs_pkg::CFG_EN_CARD_A]) ||
            (pinChange[wrs_pkg::PIN_CARD_B] && cfg_reg[wrs_pkg::CFG_EN_CARD_B]); // RQ5 RQ11
        flagSet[wrs_pkg::FLG_BUS] = pinChange[wrs_pkg::PIN_BUS]; // RQ6 RQ11
        flagSet[wrs_pkg::FLG_PORT_A] =
            pinChange[wrs_pkg::PIN_PORT_A] && cfg_reg[wrs_pkg::CFG_EN_PORT_A]; // RQ7 RQ11
        flagSet[wrs_pkg::FLG_PORT_B] =
            pinChange[wrs_pkg::PIN_PORT_B] && cfg_reg[wrs_pkg::CFG_EN_PORT_B]; // RQ8 RQ11
    end

    // write ones to the flag field clears; zeros leave flags alone
    assign wrWake = dphWrite_reg && (dphAddr_reg == wrs_pkg::ADDR_WAKE_STATUS);
    assign flagClear = wrWake ?
        hwdata[wrs_pkg::FLAG_LSB +: wrs_pkg::NUM_FLAGS] : '0; // RQ10
    // irq status clears on any read of it, sampled at address phase
    assign irqClear = {wrs_pkg::NUM_FLAGS{readAccess &&
        (offs == wrs_pkg::ADDR_IRQ_STATUS)}};

    wrs_sticky_bits #(
        .WIDTH(wrs_pkg::NUM_FLAGS)
    ) u_flags (
        .clk(clk),
        .reset(reset),
        .setBits(flagSet),
        .clearBits(flagClear),
        .bits(flags)
    );

    wrs_sticky_bits #(
        .WIDTH(wrs_pkg::NUM_FLAGS)
    ) u_irq_stat (
        .clk(clk),
        .reset(reset),
        .setBits(flagSet),
        .clearBits(irqClear),
        .bits(irqStat)
    );

    // levels in the low nibble, flags above
    assign wakeStatus = {flags, pinLevel[wrs_pkg::PIN_PORT_B:wrs_pkg::PIN_CARD_A]}; // RQ1 RQ2 RQ4

    // ======================================================
    // next-state of the bus slave and software registers
    always_comb begin
        cfg_next = cfg_reg;
        usbMask_next = usbMask_reg;
        irqMask_next = irqMask_reg;
        dphWrite_next = addrPhase && hwrite;
        dphAddr_next = addrPhase ? offs : dphAddr_reg;
        hrdata_next = hrdata_reg;
        // read data is captured at the address phase edge
        if (readAccess) begin
            case (offs)
                wrs_pkg::ADDR_WAKE_STATUS: hrdata_next = {24'h000000, wakeStatus};
                wrs_pkg::ADDR_CONFIG: hrdata_next = {28'h0000000, cfg_reg};
                wrs_pkg::ADDR_USB_MASK: hrdata_next = {31'h00000000, usbMask_reg};
                wrs_pkg::ADDR_IRQ_STATUS: hrdata_next = {28'h0000000, irqStat};
                wrs_pkg::ADDR_IRQ_MASK: hrdata_next = {28'h0000000, irqMask_reg};
                // unmapped reads return zero
                default: hrdata_next = 32'h00000000;
            endcase
        end
        // writes land at the end of their data phase
        if (dphWrite_reg) begin
            case (dphAddr_reg)
                wrs_pkg::ADDR_CONFIG: cfg_next = hwdata[3:0];
                wrs_pkg::ADDR_USB_MASK: usbMask_next = hwdata[0];
                wrs_pkg::ADDR_IRQ_MASK: irqMask_next = hwdata[3:0];
                // status registers and holes take no stored value
                default: cfg_next = cfg_reg;
            endcase
        end
        // wake interrupt plus masked irq status, one line out
        irq_next = ((|flags) && usbMask_reg) || (|(irqStat & irqMask_reg)); // RQ12
    end

    // registers only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            cfg_reg <= wrs_pkg::CFG_RESET;
            usbMask_reg <= wrs_pkg::USB_MASK_RESET;
            irqMask_reg <= wrs_pkg::IRQ_MASK_RESET;
            dphWrite_reg <= 1'b0;
            dphAddr_reg <= 8'h00;
            hrdata_reg <= 32'h00000000;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
            irq_reg <= 1'b0;
        end else begin
            cfg_reg <= cfg_next;
            usbMask_reg <= usbMask_next;
            irqMask_reg <= irqMask_next;
            dphWrite_reg <= dphWrite_next;
            dphAddr_reg <= dphAddr_next;
            hrdata_reg <= hrdata_next;
            hreadyout_reg <= 1'b1;
            hresp_reg <= 1'b0;
            irq_reg <= irq_next;
        end
    end

    assign hreadyout = hreadyout_reg;
    assign hrdata = hrdata_reg;
    assign hresp = hresp_reg;
    assign irq = irq_reg;

    // ======================================================
    // checks
    localparam int IRQ_LAT = 2;

    default clocking cb @(posedge clk); endclocking
    default disable iff (reset);

    sequence s_read(logic [7:0] off);
        hsel && htrans[1] && hready && !hwrite && haddr[7:0] == off;
    endsequence

    sequence s_write(logic [7:0] off);
        hsel && htrans[1] && hready && hwrite && haddr[7:0] == off;
    endsequence

    a_card_a_bit: assert property ( // RQ1
        s_read(wrs_pkg::ADDR_WAKE_STATUS) |=>
            hrdata[0] == $past(pinLevel[wrs_pkg::PIN_CARD_A]))
        else $error("card A level bit wrong");
    a_card_b_bit: assert property ( // RQ2
        s_read(wrs_pkg::ADDR_WAKE_STATUS) |=>
            hrdata[1] == $past(pinLevel[wrs_pkg::PIN_CARD_B]))
        else $error("card B level bit wrong");
    a_port_bits: assert property ( // RQ4
        s_read(wrs_pkg::ADDR_WAKE_STATUS) |=>
            hrdata[3:2] == $past(pinLevel[wrs_pkg::PIN_PORT_B:wrs_pkg::PIN_PORT_A]))
        else $error("port level bits wrong");
    a_card_flag_set: assert property ( // RQ5
        pinChange[wrs_pkg::PIN_CARD_A] && cfg_reg[wrs_pkg::CFG_EN_CARD_A] |=>
            flags[wrs_pkg::FLG_CARD])
        else $error("card change flag not set");
    a_bus_flag_set: assert property ( // RQ6
        pinChange[wrs_pkg::PIN_BUS] |=> flags[wrs_pkg::FLG_BUS])
        else $error("bus power change flag not set");
    a_port_a_flag: assert property ( // RQ7
        pinChange[wrs_pkg::PIN_PORT_A] && cfg_reg[wrs_pkg::CFG_EN_PORT_A] |=>
            flags[wrs_pkg::FLG_PORT_A])
        else $error("port A change flag not set");
    a_port_b_flag: assert property ( // RQ8
        pinChange[wrs_pkg::PIN_PORT_B] && cfg_reg[wrs_pkg::CFG_EN_PORT_B] |=>
            flags[wrs_pkg::FLG_PORT_B])
        else $error("port B change flag not set");
    a_write_one_clear: assert property ( // RQ10
        s_write(wrs_pkg::ADDR_WAKE_STATUS) ##1
            (hwdata[wrs_pkg::FLAG_LSB + wrs_pkg::FLG_PORT_A] &&
             !flagSet[wrs_pkg::FLG_PORT_A]) |=> !flags[wrs_pkg::FLG_PORT_A])
        else $error("write one did not clear flag");
    a_write_zero_keep: assert property ( // RQ10
        s_write(wrs_pkg::ADDR_WAKE_STATUS) ##1
            (!hwdata[wrs_pkg::FLAG_LSB + wrs_pkg::FLG_BUS] &&
             flags[wrs_pkg::FLG_BUS]) |=> flags[wrs_pkg::FLG_BUS])
        else $error("write zero cleared flag");
    a_gate_disabled: assert property ( // RQ11
        !flags[wrs_pkg::FLG_PORT_B] && !cfg_reg[wrs_pkg::CFG_EN_PORT_B] |=>
            !flags[wrs_pkg::FLG_PORT_B])
        else $error("disabled flag set");
    a_wake_irq: assert property ( // RQ12
        (|flags) && usbMask_reg |-> ##[1:IRQ_LAT] irq)
        else $error("wake interrupt not raised");
    a_irq_quiet: assert property ( // RQ12
        !usbMask_reg && irqMask_reg == '0 |=> !irq)
        else $error("interrupt raised while masked");

    // ======================================================
    // further checks: flag readout, enables, bus writes, status path

    // the flag nibble of a read must be the flags of the capture edge
    a_flag_bits: assert property ( // RQ5 RQ6 RQ7 RQ8
        s_read(wrs_pkg::ADDR_WAKE_STATUS) |=>
            hrdata[wrs_pkg::FLAG_LSB +: wrs_pkg::NUM_FLAGS] == $past(flags))
        else $error("change flag bits read wrong");
    // the second card pin feeds the same shared flag
    a_card_b_flag: assert property ( // RQ5
        pinChange[wrs_pkg::PIN_CARD_B] && cfg_reg[wrs_pkg::CFG_EN_CARD_B] |=>
            flags[wrs_pkg::FLG_CARD])
        else $error("card B change flag not set");
    // both card enables off must keep the shared card flag down
    a_gate_card: assert property ( // RQ11
        !flags[wrs_pkg::FLG_CARD] && !cfg_reg[wrs_pkg::CFG_EN_CARD_A] &&
            !cfg_reg[wrs_pkg::CFG_EN_CARD_B] |=> !flags[wrs_pkg::FLG_CARD])
        else $error("disabled card flag set");

    // a config write: address phase, then its data phase
    sequence s_cfg_write;
        s_write(wrs_pkg::ADDR_CONFIG) ##1 1'b1;
    endsequence
    // enables take the data that stood in the data phase
    a_cfg_lands: assert property ( // RQ11
        s_cfg_write |=> cfg_reg == $past(hwdata[3:0]))
        else $error("enable write did not land");

    // a read clears the status unless an event arrives with it
    a_stat_read_clear: assert property ( // RQ12
        s_read(wrs_pkg::ADDR_IRQ_STATUS) ##0 (flagSet == '0) |=> irqStat == '0)
        else $error("irq status not cleared by read");
    // the status path raises the line whatever the wake enable says
    a_status_irq: assert property ( // RQ12
        (|(irqStat & irqMask_reg)) |=> irq)
        else $error("masked status did not raise interrupt");
    // no flag and no status bit: the line must be low after one edge
    a_irq_drop: assert property ( // RQ12
        flags == '0 && irqStat == '0 |=> !irq)
        else $error("interrupt without cause");
endmodule
`default_nettype wire

// ===== core/wrs_pkg.sv
// Behaviour
// RQ1 - bit0 shows debounced card A level, resets 1
// RQ2 - bit1 shows debounced card B level, resets 1
// RQ3 - firmware judges insertion from both card bits
// RQ4 - bits 2,3 mirror debounced port pins, reset 0
// RQ5 - bit4 sets on either card pin change
// RQ6 - bit5 sets on bus power pin change
// RQ7 - bit6 sets on port pin A change
// RQ8 - bit7 sets on port pin B change
// RQ9 - firmware rereads card bits after card flag
// RQ10 - writing one clears a flag, zero ignored
// RQ11 - flags gated by enables, bus power always
// RQ12 - OR of flags, unmasked, raises wake interrupt
// RQ13 - levels accepted only after stable 1.28 ms

`default_nettype none

// ==========================================================
// shared constants of the wake reason block
package wrs_pkg;
    // register byte offsets on the bus
    localparam int ADDR_W = 8;
    localparam logic [7:0] ADDR_WAKE_STATUS = 8'h00;
    localparam logic [7:0] ADDR_CONFIG = 8'h04;
    localparam logic [7:0] ADDR_USB_MASK = 8'h08;
    localparam logic [7:0] ADDR_IRQ_STATUS = 8'h0C;
    localparam logic [7:0] ADDR_IRQ_MASK = 8'h10;

    // ======================================================
    // pin channel indices for the debounce array
    localparam int NUM_PINS = 5;
    localparam int PIN_CARD_A = 0;
    localparam int PIN_CARD_B = 1;
    localparam int PIN_PORT_A = 2;
    localparam int PIN_PORT_B = 3;
    localparam int PIN_BUS = 4;
    // card pins idle high (absent), others low
    localparam logic [4:0] LEVEL_RESET = 5'h03;

    // ======================================================
    // change flag indices; in wake status at FLAG_LSB + index
    localparam int NUM_FLAGS = 4;
    localparam int FLG_CARD = 0;
    localparam int FLG_BUS = 1;
    localparam int FLG_PORT_A = 2;
    localparam int FLG_PORT_B = 3;
    localparam int LEVEL_LSB = 0;
    localparam int FLAG_LSB = 4;
    localparam logic [3:0] FLAGS_RESET = 4'h0;

    // ======================================================
    // configuration register: detection enables
    localparam int CFG_EN_CARD_A = 0;
    localparam int CFG_EN_CARD_B = 1;
    localparam int CFG_EN_PORT_A = 2;
    localparam int CFG_EN_PORT_B = 3;
    localparam logic [3:0] CFG_RESET = 4'h0;
    // usb interrupt mask: wake clock interrupt enable
    localparam logic USB_MASK_RESET = 1'b0;
    localparam logic [3:0] IRQ_MASK_RESET = 4'h0;

    // ======================================================
    // timing
    localparam int CLK_FREQ_MHZ = 10;
    localparam int DEBOUNCE_TIME_US = 1280;
    localparam int DEBOUNCE_CYCLES = DEBOUNCE_TIME_US * CLK_FREQ_MHZ;
endpackage
`default_nettype wire

// ===== core/wrs_debounce.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// one pin debouncer with change pulse
module wrs_debounce #(
    parameter int CYCLES = 12800,
    parameter logic RESET_LEVEL = 1'b0
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic pinIn,
    output logic level,
    output logic changePulse
);
    localparam int CW = $clog2(CYCLES + 1);
    localparam logic [CW-1:0] LIMIT = CW'(CYCLES);

    logic [CW-1:0] count_reg, count_next; // cycles the pin has differed
    logic level_reg, level_next;          // accepted level
    logic change_reg, change_next;        // one cycle on acceptance

    // a new level needs CYCLES+1 differing samples, so strictly longer
    // than the interval; any return to the old level restarts the count
    always_comb begin
        count_next = '0;
        level_next = level_reg;
        change_next = 1'b0;
        if (pinIn != level_reg) begin
            if (count_reg == LIMIT) begin
                level_next = pinIn; // RQ13
                change_next = 1'b1;
            end else begin
                count_next = count_reg + 1'b1;
            end
        end
    end

    // registers only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            count_reg <= '0;
            level_reg <= RESET_LEVEL;
            change_reg <= 1'b0;
        end else begin
            count_reg <= count_next;
            level_reg <= level_next;
            change_reg <= change_next;
        end
    end

    assign level = level_reg;
    assign changePulse = change_reg;

    a_accept_after_hold: assert property (@(posedge clk) disable iff (reset) // RQ13
        $changed(level_reg) |-> $past(count_reg) == LIMIT && change_reg)
        else $error("level accepted before full debounce time");
    a_glitch_restart: assert property (@(posedge clk) disable iff (reset) // RQ13
        (pinIn == level_reg) |=> count_reg == '0 && $stable(level_reg))
        else $error("debounce count not restarted by glitch");
endmodule
`default_nettype wire

// ===== core/wrs_sticky_bits.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// sticky flag bits, set has priority over clear
module wrs_sticky_bits #(
    parameter int WIDTH = 4
) (
    input wire logic clk,
    input wire logic reset,
    input wire logic [WIDTH-1:0] setBits,
    input wire logic [WIDTH-1:0] clearBits,
    output logic [WIDTH-1:0] bits
);
    logic [WIDTH-1:0] bits_reg, bits_next; // held flags

    // an event in the clearing cycle survives the clear
    always_comb begin
        bits_next = (bits_reg & ~clearBits) | setBits;
    end

    // registers only
    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            bits_reg <= '0;
        end else begin
            bits_reg <= bits_next;
        end
    end

    assign bits = bits_reg;

    a_set_wins: assert property (@(posedge clk) disable iff (reset) // RQ10
        (|setBits) |=> (bits_reg & $past(setBits)) == $past(setBits))
        else $error("set event lost");
    a_clear_acts: assert property (@(posedge clk) disable iff (reset) // RQ10
        (|(clearBits & ~setBits)) |=> (bits_reg & $past(clearBits & ~setBits)) == '0)
        else $error("flag not cleared");
    a_hold_quiet: assert property (@(posedge clk) disable iff (reset) // RQ10
        (setBits == '0 && clearBits == '0) |=> $stable(bits_reg))
        else $error("flag changed without cause");
endmodule
`default_nettype wire

// ===== verification/wrs_pin_model.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// far side: card detect, port and bus power pins
module wrs_pin_model (
    input wire logic clk,
    input wire logic reset,
    input wire logic [4:0] wantLevels,
    output logic cardDetectAPin,
    output logic cardDetectBPin,
    output logic portPinA,
    output logic portPinB,
    output logic busPowerPin
);
    logic [4:0] pinReg; // levels now on the pins
    logic [4:0] pinNext; // levels after the next edge

    // ======================================================
    // pins follow the command one edge late, so the block sees
    // exactly as many high samples as the command lasted cycles
    always_comb begin
        pinNext = wantLevels;
    end

    always_ff @(posedge clk or posedge reset) begin
        if (reset) begin
            // cards absent, other pins low, matching idle wiring
            pinReg <= wrs_pkg::LEVEL_RESET;
        end else begin
            pinReg <= pinNext;
        end
    end

    assign cardDetectAPin = pinReg[wrs_pkg::PIN_CARD_A];
    assign cardDetectBPin = pinReg[wrs_pkg::PIN_CARD_B];
    assign portPinA = pinReg[wrs_pkg::PIN_PORT_A];
    assign portPinB = pinReg[wrs_pkg::PIN_PORT_B];
    assign busPowerPin = pinReg[wrs_pkg::PIN_BUS];
endmodule
`default_nettype wire

// ===== verification/wrs_top_test.sv
`timescale 1ns/1ps
`default_nettype none
// ==========================================================
// register level test of the wake reason block
module wrs_top_test;
    localparam int DEB = 8; // short debounce keeps the run brief
    localparam int SETTLE = DEB + 6; // accept, flag and irq latency with margin
    logic clk = 1'b0;
    logic reset = 1'b1;
    logic hsel = 1'b0;
    logic [31:0] haddr = 32'h0;
    logic [1:0] htrans = 2'h0;
    logic hwrite = 1'b0;
    logic [2:0] hsize = 3'h2; // always whole words
    logic [31:0] hwdata = 32'h0;
    logic [4:0] wantLevels = 5'h03; // commanded pin levels
    wire logic hreadyout;
    wire logic [31:0] hrdata;
    wire logic hresp;
    wire logic irq;
    wire logic cardA, cardB, portA, portB, busPower;
    int failCount = 0;
    int nCompared = 0;

    always #50 clk = ~clk; // 10 MHz

    wrs_top #(.DEBOUNCE_CYCLES(DEB)) i_wrs_top (
        .clk(clk), .reset(reset), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(hsize), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .cardDetectAPin(cardA), .cardDetectBPin(cardB), .portPinA(portA),
        .portPinB(portB), .busPowerPin(busPower), .irq(irq)
    );

    wrs_pin_model i_wrs_pin_model (
        .clk(clk), .reset(reset), .wantLevels(wantLevels),
        .cardDetectAPin(cardA), .cardDetectBPin(cardB), .portPinA(portA),
        .portPinB(portB), .busPowerPin(busPower)
    );

    // ======================================================
    // verdict, reached from the main sequence or a timeout
    task automatic tallyAndFinish();
        $display("compared %0d, mismatches %0d", nCompared, failCount);
        if (failCount == 0 && nCompared > 0) begin
            $display("== PASSED ==");
        end else begin
            $display("== FAILED ==");
        end
        $finish;
    endtask

    task automatic checkWord(input logic [31:0] got, input logic [31:0] exp);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask

    task automatic checkBit(input logic got, input logic exp);
        nCompared++;
        if (got !== exp) begin
            failCount++;
            $display("wrong value at %0t: got 0x%h expected 0x%h", $time, got, exp);
        end
    endtask

    task automatic cycles(input int n);
        repeat (n) @(posedge clk);
    endtask

    // hready is sampled at the edge, before that edge's updates land
    task automatic waitReady();
        int n;
        n = 0;
        @(posedge clk);
        while (hreadyout !== 1'b1) begin
            n++;
            if (n > 16) begin
                failCount++;
                $display("wrong value at %0t: got 0x%h expected 0x1", $time, hreadyout);
                tallyAndFinish();
            end
            @(posedge clk);
        end
    endtask

    // ======================================================
    // one ahb-lite single word transfer; entered just after an edge
    task automatic busXfer(input logic wr, input logic [7:0] addr,
                           input logic [31:0] wdata, output logic [31:0] rdata);
        hsel <= 1'b1;
        htrans <= 2'h2;
        hwrite <= wr;
        haddr <= {24'h0, addr};
        waitReady();
        hsel <= 1'b0;
        htrans <= 2'h0;
        hwdata <= wdata;
        waitReady();
        rdata = hrdata;
        checkBit(hresp, 1'b0);
    endtask

    task automatic regWrite(input logic [7:0] addr, input logic [31:0] data);
        logic [31:0] unused;
        busXfer(1'b1, addr, data, unused);
    endtask

    task automatic regExpect(input logic [7:0] addr, input logic [31:0] exp);
        logic [31:0] got;
        busXfer(1'b0, addr, 32'h0, got);
        checkWord(got, exp);
    endtask

    // pulse a pin away from its level for exactly w cycles
    task automatic pinPulse(input int idx, input int w);
        wantLevels[idx] <= ~wantLevels[idx];
        cycles(w);
        wantLevels[idx] <= ~wantLevels[idx];
        cycles(1);
    endtask

    task automatic pinSet(input int idx, input logic v);
        wantLevels[idx] <= v;
        cycles(SETTLE);
    endtask

    task automatic endTest(input string name);
        $display("test %s done", name);
    endtask

    // ======================================================
    // main sequence
    initial begin
        cycles(16);
        reset <= 1'b0;
        // reset values and an unmapped place
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'h03);
        regExpect(wrs_pkg::ADDR_CONFIG, 32'h0);
        regExpect(wrs_pkg::ADDR_USB_MASK, 32'h0);
        regExpect(wrs_pkg::ADDR_IRQ_STATUS, 32'h0);
        regExpect(wrs_pkg::ADDR_IRQ_MASK, 32'h0);
        regWrite(8'h20, 32'hFFFF_FFFF);
        regExpect(8'h20, 32'h0);
        regWrite(wrs_pkg::ADDR_WAKE_STATUS, 32'h0F); // read-only levels ignore writes
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'h03);
        checkBit(irq, 1'b0);
        endTest("reset");

        // debounce boundary on port pin A
        regWrite(wrs_pkg::ADDR_CONFIG, 32'h0F);
        pinPulse(wrs_pkg::PIN_PORT_A, DEB);
        cycles(SETTLE);
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'h03);
        pinPulse(wrs_pkg::PIN_PORT_A, DEB + 1);
        cycles(2 * SETTLE);
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'h43);
        endTest("debounce");

        // card detect pins share one change flag
        pinSet(wrs_pkg::PIN_CARD_A, 1'b0);
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'h52);
        pinSet(wrs_pkg::PIN_CARD_B, 1'b0);
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'h50);
        endTest("card");

        // write one clears, write zero leaves
        regWrite(wrs_pkg::ADDR_WAKE_STATUS, 32'h00);
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'h50);
        regWrite(wrs_pkg::ADDR_WAKE_STATUS, 32'h10);
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'h40);
        regWrite(wrs_pkg::ADDR_WAKE_STATUS, 32'h40);
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'h00);
        endTest("clear");

        // enables gate the flags; bus power is never gated
        regWrite(wrs_pkg::ADDR_CONFIG, 32'h00);
        pinSet(wrs_pkg::PIN_BUS, 1'b1);
        pinSet(wrs_pkg::PIN_PORT_B, 1'b1);
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'h28);
        regWrite(wrs_pkg::ADDR_CONFIG, 32'h08);
        regExpect(wrs_pkg::ADDR_CONFIG, 32'h08);
        pinSet(wrs_pkg::PIN_PORT_B, 1'b0);
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'hA0);
        endTest("enables");

        // wake interrupt: masked, raised, cleared, then the status path
        checkBit(irq, 1'b0);
        regWrite(wrs_pkg::ADDR_USB_MASK, 32'h1);
        cycles(2);
        checkBit(irq, 1'b1);
        regWrite(wrs_pkg::ADDR_WAKE_STATUS, 32'hA0);
        cycles(2);
        checkBit(irq, 1'b0);
        regExpect(wrs_pkg::ADDR_IRQ_STATUS, 32'h0F);
        regExpect(wrs_pkg::ADDR_IRQ_STATUS, 32'h00);
        regWrite(wrs_pkg::ADDR_IRQ_MASK, 32'h2);
        regWrite(wrs_pkg::ADDR_USB_MASK, 32'h0);
        pinSet(wrs_pkg::PIN_BUS, 1'b0);
        checkBit(irq, 1'b1);
        regExpect(wrs_pkg::ADDR_WAKE_STATUS, 32'h20);
        regExpect(wrs_pkg::ADDR_IRQ_STATUS, 32'h02);
        cycles(2);
        checkBit(irq, 1'b0);
        endTest("interrupt");
        tallyAndFinish();
    end
endmodule
`default_nettype wire
